// *** src/pwm_map.svh ***
// Purpose: constants for the quad PWM driver control logic
// Assumes: included by bare name from the package and the modules
// Notes: frame layout, reset values and link timing counts
// What this block does
// - Low supply forces outputs off, state kept
// - Either external reset input clears the duty codes
// - PWM period is 32 oscillator periods
// - External clock on oscillator input drives timebase
// - Overcurrent switches channel off for cycle
// - Code n gives n/16 or (16-n)/16, 0 off
// - Channel k code in bits 4(k-1) upward
// - Latch flyback comparator at PWM rising edge
// - Latch off-state comparator at PWM falling edge
// - Report reset input levels in bits 8, 9
// - Report thermal flag in bit 10
// - Overcurrent at PWM fall into bits 11-14
// - Transmitted bit 15 is always one
// - Output driven only while chip select low
// - Sample one input bit per falling clock
// - Chip select rise applies codes, input ignored
// - Apply only for nonzero multiple of 16 clocks
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH
`define FRAME_W 16
`define DUTY_W 4
`define PHASE_W 5
`define PHASE_LAST 5'h1F
`define DIAG_RESA_BIT 8
`define DIAG_RESB_BIT 9
`define DIAG_THERM_BIT 10
`define DIAG_OC_BIT 11
`define DIAG_FRAME_BIT 15
`define DUTY_RESET 16'h0000
`define OC_FLAG_RESET 1'b1
`define SYNC_W 18
`define SYNC_RESET 18'h20000
`define CLK_PERIOD_NS 4
`define SCLK_MIN_PHASE_NS 200
`define SCLK_MIN_PHASE_CYC ((`SCLK_MIN_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SDO_Z_MAX_NS 400
`define SDO_Z_MAX_CYC (`SDO_Z_MAX_NS / `CLK_PERIOD_NS)
`endif

// *** src/pwm_pkg.sv ***
// Purpose: shared types of the quad PWM driver
// Assumes: pwm_map.svh holds the widths
// Notes: none
`include "pwm_map.svh"
package pwm_pkg;
   typedef logic [`DUTY_W-1:0] duty_code_t;
   typedef logic [`PHASE_W-1:0] phase_t;
   typedef logic [`FRAME_W-1:0] frame_t;
endpackage

// *** src/pwm_channel.sv ***
// Purpose: one PWM channel with its diagnostic latches
// Assumes: sense inputs already synchronised to clk
// Notes: INV selects the (16-n)/16 channels
`timescale 1ns/100ps
`include "pwm_map.svh"
module pwm_channel import pwm_pkg::*; #(
   parameter bit INV = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Timebase
   input wire logic tick,
   input wire phase_t phase,
   // Control
   input wire duty_code_t code,
   input wire logic uv,
   // Sense
   input wire logic fly_cmp,
   input wire logic off_cmp,
   input wire logic oc,
   // Results
   output logic out_r,
   output logic fly_r,
   output logic off_r,
   output logic oc_flag_r
);
   logic pwm;
   logic nz;
   logic wrap;
   logic kill_r;
   logic kill_nxt;
   logic pwm_q;
   duty_code_t thr;

   // Code 0 still runs a 15/16 internal signal so diagnosis keeps working
   always_comb begin
      nz = (code != 4'h0);
      if (INV) begin
         thr = nz ? code : 4'h1;
         pwm = (phase[4:1] >= thr);
      end else begin
         thr = nz ? code : 4'hF;
         pwm = (phase[4:1] < thr);
      end
   end

   assign wrap = tick && (phase == `PHASE_LAST);
   // Set wins over the period-end clear so a late overcurrent is not lost
   assign kill_nxt = oc | (kill_r & ~wrap);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kill_r <= 1'b0;
         pwm_q <= 1'b0;
         out_r <= 1'b0;
      end else begin
         kill_r <= kill_nxt;
         pwm_q <= pwm;
         out_r <= pwm & nz & ~uv & ~kill_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fly_r <= 1'b0;
         off_r <= 1'b0;
         oc_flag_r <= `OC_FLAG_RESET;
      end else begin
         if (pwm && !pwm_q) begin
            fly_r <= fly_cmp;
         end
         if (!pwm && pwm_q) begin
            off_r <= off_cmp;
            oc_flag_r <= ~oc;
         end
      end
   end

   sequence pwm_rise_s;
      pwm && !pwm_q;
   endsequence
   sequence pwm_fall_s;
      !pwm && pwm_q;
   endsequence

   AST_UV_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      uv |=> !out_r) else $error("output on during low supply");
   AST_OC_CUT: assert property (@(posedge clk) disable iff (!rst_n)
      oc ##1 !wrap |=> !out_r) else $error("output on after overcurrent in cycle");
   AST_ZERO_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      code == 4'h0 |=> !out_r) else $error("output on with zero code");
   AST_FLY_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
      pwm_rise_s |=> fly_r == $past(fly_cmp)) else $error("flyback not latched");
   AST_OFF_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
      pwm_fall_s |=> off_r == $past(off_cmp)) else $error("off-state not latched");
   AST_OC_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      pwm_fall_s |=> oc_flag_r == !$past(oc)) else $error("overcurrent flag wrong");
endmodule // pwm_channel

// *** src/quad_pwm_driver_serial_ctrl.sv ***
// Purpose: serial link, timebase and four PWM channels
// Assumes: sclk idles low outside frames; pins async to clk
// Notes: link logic runs on sclk, words cross quasi-static
`timescale 1ns/100ps
`include "pwm_map.svh"
module quad_pwm_driver_serial_ctrl import pwm_pkg::*; (
   // System clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo_o,
   output logic sdo_oe,
   // Reset pins, supply and temperature
   input wire logic ext_reset_a_n,
   input wire logic ext_reset_b_n,
   input wire logic vcc_low,
   input wire logic thermal_flag,
   // Oscillator
   input wire logic osc,
   // Channel sense
   input wire logic [3:0] flyback_comparator,
   input wire logic [3:0] offstate_comparator,
   input wire logic [3:0] overcurrent,
   // Channel drive
   output logic [3:0] ch_out
);
   localparam int ZMAX = `SDO_Z_MAX_CYC;

   // Reset release
   logic rst_q1;
   logic rst_n_r;

   // Pin synchroniser
   logic [`SYNC_W-1:0] in_raw;
   logic [`SYNC_W-1:0] sync1_r;
   logic [`SYNC_W-1:0] sync2_r;
   logic cs_s;
   logic ext_a_s;
   logic ext_b_s;
   logic vcc_low_s;
   logic therm_s;
   logic osc_s;
   logic [3:0] fly_s;
   logic [3:0] off_s;
   logic [3:0] oc_s;

   // Timebase
   logic osc_q;
   logic tick;
   phase_t phase_r;

   // Control state
   logic ext_rst;
   logic cs_q;
   logic cs_rise;
   logic frame_ok;
   logic tog_seen_r;
   frame_t duty_r;
   frame_t diag;
   frame_t diag_hold_r;
   logic sdo_oe_r;

   // Channel results
   logic [3:0] out_w;
   logic [3:0] fly_w;
   logic [3:0] off_w;
   logic [3:0] ocf_w;

   // Link domain
   frame_t rx_r;
   duty_code_t bit_cnt_r;
   logic rx_first_r;
   logic tx_first_r;
   logic [`FRAME_W-2:0] tx_r;
   logic sdo_bit_r;
   logic frame_tog_r;

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_q1 <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n_r <= rst_q1;
      end
   end

   // Every pin except sclk and sdi passes two flip-flops before clk logic reads it; the link domain reads cs_n raw
   assign in_raw = {cs_n, ext_reset_a_n, ext_reset_b_n, vcc_low, thermal_flag,
                    osc, flyback_comparator, offstate_comparator, overcurrent};

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sync1_r <= `SYNC_RESET;
         sync2_r <= `SYNC_RESET;
      end else begin
         sync1_r <= in_raw;
         sync2_r <= sync1_r;
      end
   end

   assign cs_s = sync2_r[17];
   assign ext_a_s = sync2_r[16];
   assign ext_b_s = sync2_r[15];
   assign vcc_low_s = sync2_r[14];
   assign therm_s = sync2_r[13];
   assign osc_s = sync2_r[12];
   assign fly_s = sync2_r[11:8];
   assign off_s = sync2_r[7:4];
   assign oc_s = sync2_r[3:0];

   // Oscillator edges, whether from the capacitor stage or a driven clock
   assign tick = osc_s & ~osc_q;

   // A 5-bit phase wraps every 32 oscillator periods
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         osc_q <= 1'b0;
         phase_r <= 5'h00;
      end else begin
         osc_q <= osc_s;
         if (tick) begin
            phase_r <= phase_r + 5'h01;
         end
      end
   end

   // Low supply is not a reset: only the two reset pins clear state
   assign ext_rst = ~ext_a_s | ~ext_b_s;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cs_q <= 1'b1;
      end else begin
         cs_q <= cs_s;
      end
   end

   assign cs_rise = cs_s & ~cs_q;
   // Counter wraps to zero only after a whole number of 16-bit words
   // A frame with no clocks leaves the toggle alone, so old data is never reapplied
   assign frame_ok = (bit_cnt_r == 4'h0) && (frame_tog_r != tog_seen_r);

   // Toggle seen at the last chip select rise, valid frame or not
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tog_seen_r <= 1'b0;
      end else if (cs_rise) begin
         tog_seen_r <= frame_tog_r;
      end
   end

   // rx_r and bit_cnt_r are static here: sclk stays low around the cs edge
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         duty_r <= `DUTY_RESET;
      end else if (ext_rst) begin
         duty_r <= `DUTY_RESET;
      end else if (cs_rise && frame_ok) begin
         duty_r <= rx_r;
      end
   end

   // Diagnostic word assembled from the channel latches
   always_comb begin
      diag = 16'h0000;
      for (int k = 0; k < 4; k++) begin
         diag[2*k] = fly_w[k];
         diag[2*k+1] = off_w[k];
         diag[`DIAG_OC_BIT+k] = ocf_w[k];
      end
      diag[`DIAG_RESA_BIT] = ext_a_s;
      diag[`DIAG_RESB_BIT] = ext_b_s;
      diag[`DIAG_THERM_BIT] = therm_s;
      diag[`DIAG_FRAME_BIT] = 1'b1;
   end

   // Frozen while a frame runs so the link domain sees a still word
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         diag_hold_r <= 16'h8000;
         sdo_oe_r <= 1'b0;
      end else begin
         if (cs_s) begin
            diag_hold_r <= diag;
         end
         sdo_oe_r <= ~cs_s;
      end
   end

   // Four channels; 2 and 4 run the complementary duty
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_ch
         pwm_channel #(
            .INV(g % 2 == 1)
         ) u_ch (
            .clk(clk),
            .rst_n(rst_n_r),
            .tick(tick),
            .phase(phase_r),
            .code(duty_r[4*g +: 4]),
            .uv(vcc_low_s),
            .fly_cmp(fly_s[g]),
            .off_cmp(off_s[g]),
            .oc(oc_s[g]),
            .out_r(out_w[g]),
            .fly_r(fly_w[g]),
            .off_r(off_w[g]),
            .oc_flag_r(ocf_w[g])
         );
      end
   endgenerate

   // Link domain: chip select high sets the first-bit flag
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rx_first_r <= 1'b1;
      end else begin
         rx_first_r <= 1'b0;
      end
   end

   // Input bit on each falling edge, shifted in at the bottom
   always_ff @(negedge sclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_r <= 16'h0000;
         bit_cnt_r <= 4'h1;
         frame_tog_r <= 1'b0;
      end else if (!cs_n) begin
         rx_r <= {rx_r[14:0], sdi};
         bit_cnt_r <= rx_first_r ? 4'h1 : bit_cnt_r + 4'h1;
         if (rx_first_r) begin
            frame_tog_r <= ~frame_tog_r;
         end
      end
   end

   // Output bit on each rising edge; after 16 bits the received bits follow
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         tx_first_r <= 1'b1;
         sdo_bit_r <= 1'b0;
         tx_r <= 15'h0000;
      end else if (tx_first_r) begin
         tx_first_r <= 1'b0;
         sdo_bit_r <= diag_hold_r[15];
         tx_r <= diag_hold_r[14:0];
      end else begin
         sdo_bit_r <= tx_r[14];
         tx_r <= {tx_r[13:0], rx_r[0]};
      end
   end

   assign sdo_o = sdo_bit_r;
   assign sdo_oe = sdo_oe_r;
   assign ch_out = out_w;

   sequence cs_rise_s;
      cs_s && !cs_q;
   endsequence
   sequence load_s;
      cs_rise_s ##0 frame_ok ##0 !ext_rst;
   endsequence
   sequence empty_frame_s;
      cs_rise_s ##0 (frame_tog_r == tog_seen_r);
   endsequence

   AST_EXT_RST: assert property (@(posedge clk) disable iff (!rst_n_r)
      ext_rst |=> duty_r == 16'h0000) else $error("duty not cleared by reset pin");
   AST_LOAD: assert property (@(posedge clk) disable iff (!rst_n_r)
      load_s |=> duty_r == $past(rx_r)) else $error("frame not applied");
   AST_NOLOAD: assert property (@(posedge clk) disable iff (!rst_n_r)
      !ext_rst && !(cs_rise && frame_ok) |=> $stable(duty_r))
      else $error("duty changed without valid frame");
   AST_UV_KEEP: assert property (@(posedge clk) disable iff (!rst_n_r)
      vcc_low_s && !ext_rst && !cs_rise |=> $stable(duty_r))
      else $error("state lost in low supply");
   AST_PERIOD: assert property (@(posedge clk) disable iff (!rst_n_r)
      tick && phase_r == 5'h1F |=> phase_r == 5'h00) else $error("period not 32");
   AST_TICK_HOLD: assert property (@(posedge clk) disable iff (!rst_n_r)
      !tick |=> $stable(phase_r)) else $error("phase moved without osc edge");
   AST_PHASE_STEP: assert property (@(posedge clk) disable iff (!rst_n_r)
      tick |=> phase_r == $past(phase_r) + 5'h01) else $error("phase step wrong");
   AST_EMPTY_FRAME: assert property (@(posedge clk) disable iff (!rst_n_r)
      empty_frame_s ##0 !ext_rst |=> $stable(duty_r))
      else $error("frame without clocks applied");
   AST_RES_BITS: assert property (@(posedge clk) disable iff (!rst_n_r)
      cs_s |=> diag_hold_r[9:8] == $past({ext_b_s, ext_a_s}))
      else $error("reset levels misreported");
   AST_THERM: assert property (@(posedge clk) disable iff (!rst_n_r)
      cs_s |=> diag_hold_r[10] == $past(therm_s)) else $error("thermal bit wrong");
   AST_FRAME_BIT: assert property (@(posedge clk) disable iff (!rst_n_r)
      cs_rise_s |-> diag_hold_r[15]) else $error("framing bit not one");
   AST_SDO_RELEASE: assert property (@(posedge clk) disable iff (!rst_n_r)
      $rose(cs_s) |-> ##[1:ZMAX] !sdo_oe_r) else $error("sdo not released");
   AST_SDO_DRIVE: assert property (@(posedge clk) disable iff (!rst_n_r)
      $fell(cs_s) |=> sdo_oe_r) else $error("sdo not driven in frame");
endmodule // quad_pwm_driver_serial_ctrl

// *** bench/mcu_link_model.sv ***
// Purpose: serial link master standing in for the controller
// Assumes: one frame at a time, called from the bench
// Notes: sclk phases are two 125 ns base ticks, so 2 MHz at most
`timescale 1ns/100ps
module mcu_link_model (
   // Link pins
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   // Status
   output logic oe_ok
);
   logic base = 1'b0;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      oe_ok = 1'b1;
      #17;
      forever #62.5 base = ~base;
   end

   // Clock stands still outside frames; 250 ns phases keep a margin on 200 ns
   task automatic xfer(input logic [31:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge base);
      cs_n = 1'b0;
      repeat (2) @(posedge base);
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         sdi = tx[n-1-i];
         repeat (2) @(posedge base);
         sclk = 1'b0;
         rx = {rx[14:0], sdo_oe ? sdo_o : ~rx[0]};
         oe_ok = oe_ok & sdo_oe;
         repeat (2) @(posedge base);
      end
      cs_n = 1'b1;
      repeat (2) @(posedge base);
      sdi = ~sdi;
   endtask
endmodule // mcu_link_model

// *** bench/quad_pwm_driver_serial_ctrl_tb.sv ***
// Purpose: self-checking bench of the quad PWM driver control logic
// Assumes: osc is a driven clock of ten clk periods
// Notes: PWM counts are taken over one whole period, so phase does not matter
`timescale 1ns/100ps
module quad_pwm_driver_serial_ctrl_tb import pwm_pkg::*;;
   localparam int OSC_CLK = 10;
   logic clk, rstn, osc, sclk, cs_n, sdi, sdo_o, sdo_oe, oe_ok;
   logic ext_reset_a_n, ext_reset_b_n, vcc_low, thermal_flag;
   logic [3:0] flyback_comparator, offstate_comparator, overcurrent, ch_out;
   frame_t rx_f;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;

   quad_pwm_driver_serial_ctrl quad_pwm_driver_serial_ctrl_i (.clk, .rstn, .sclk, .cs_n,
      .sdi, .sdo_o, .sdo_oe, .ext_reset_a_n, .ext_reset_b_n, .vcc_low, .thermal_flag,
      .osc, .flyback_comparator, .offstate_comparator, .overcurrent, .ch_out);
   mcu_link_model mcu_link_model_i (.sclk, .cs_n, .sdi, .sdo_o, .sdo_oe, .oe_ok);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Driven oscillator, offset so its edges never meet clk edges
   initial begin
      osc = 1'b0;
      #1;
      forever #20 osc = ~osc;
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic send(input logic [31:0] tx, input int n);
      mcu_link_model_i.xfer(tx, n, rx_f);
      repeat (50) @(negedge clk);
      chk(sdo_oe, 1'b0);
      chk(oe_ok, 1'b1);
   endtask

   // High time per channel over one PWM period; kill marks channels held off
   task automatic chk_pwm(input logic [15:0] f, input logic [3:0] kill);
      logic [31:0] hi [4] = '{default: 32'h0};
      int n;
      repeat (32 * OSC_CLK) begin
         @(negedge clk);
         for (int k = 0; k < 4; k++) hi[k] = hi[k] + ch_out[k];
      end
      for (int k = 0; k < 4; k++) begin
         n = f[4*k +: 4];
         chk(hi[k], (kill[k] || n == 0) ? 0 : (k[0] ? 16 - n : n) * 2 * OSC_CLK);
      end
   endtask

   task automatic t_duty();
      logic [15:0] f;
      for (int n = 0; n < 16; n++) begin
         for (int k = 0; k < 4; k++) f[4*k +: 4] = 4'(n + k);
         send({16'h0000, f}, 16);
         chk_pwm(f, 4'h0);
      end
      $display("test duty done");
   endtask

   task automatic t_diag(input logic [3:0] p);
      logic [15:0] e;
      @(negedge clk);
      flyback_comparator = p;
      offstate_comparator = ~p;
      overcurrent = p;
      thermal_flag = p[0];
      repeat (400) @(negedge clk);
      send(32'h0000_8888, 16);
      e = {1'b1, ~p, p[0], 2'b11, 8'h00};
      for (int k = 0; k < 4; k++) e[2*k +: 2] = {~p[k], p[k]};
      chk(rx_f, e);
      chk_pwm(16'h8888, p);
      overcurrent = 4'h0;
      repeat (400) @(negedge clk);
      $display("test diag done");
   endtask

   // Pins read back through a short frame, which must not load codes
   task automatic t_rst(input logic b);
      send(32'h0000_5555, 16);
      if (b) ext_reset_b_n = 1'b0;
      else ext_reset_a_n = 1'b0;
      repeat (20) @(negedge clk);
      send(32'h0000_7777, 15);
      chk(rx_f[8:7], b ? 2'b01 : 2'b10);
      ext_reset_a_n = 1'b1;
      ext_reset_b_n = 1'b1;
      repeat (10) @(negedge clk);
      chk_pwm(16'h0000, 4'h0);
      $display("test reset done");
   endtask

   task automatic t_count();
      send(32'h0000_2222, 16);
      send(32'h0001_7777, 17);
      chk_pwm(16'h2222, 4'h0);
      send(32'hF0F0_3333, 32);
      chk_pwm(16'h3333, 4'h0);
      // A frame with no clocks after a reset pin must not bring old codes back
      ext_reset_a_n = 1'b0;
      repeat (20) @(negedge clk);
      ext_reset_a_n = 1'b1;
      repeat (10) @(negedge clk);
      send(32'h0000_3333, 0);
      chk_pwm(16'h0000, 4'h0);
      $display("test count done");
   endtask

   task automatic t_uv();
      send(32'h0000_8888, 16);
      vcc_low = 1'b1;
      repeat (10) @(negedge clk);
      chk_pwm(16'h8888, 4'hF);
      vcc_low = 1'b0;
      repeat (10) @(negedge clk);
      chk_pwm(16'h8888, 4'h0);
      $display("test undervoltage done");
   endtask

   initial begin
      rstn = 1'b0;
      ext_reset_a_n = 1'b1;
      ext_reset_b_n = 1'b1;
      vcc_low = 1'b0;
      thermal_flag = 1'b1;
      flyback_comparator = 4'h0;
      offstate_comparator = 4'h0;
      overcurrent = 4'h0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      t_duty();
      t_diag(4'h5);
      t_diag(4'hA);
      t_rst(1'b0);
      t_rst(1'b1);
      t_count();
      t_uv();
      wrap_up();
   end
endmodule // quad_pwm_driver_serial_ctrl_tb
